// ==== dra_timer.sv ====
// constants package and refresh interval timer for the refresh arbiter
`timescale 1ns/1ns
package dra_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // spacing between row refreshes, longest time rounds down
  localparam int REF_INTERVAL_NS = 14500;
  localparam int REF_INTERVAL_CYC = REF_INTERVAL_NS / CLK_PERIOD_NS;
  // row strobe width of a refresh, least time rounds up
  localparam int REF_STROBE_NS = 250;
  localparam int REF_STROBE_CYC =
    (REF_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // whole refresh operation including strobe precharge
  localparam int REF_TOTAL_NS = 300;
  localparam int REF_TOTAL_CYC =
    (REF_TOTAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // longest stall an access may see behind a refresh
  localparam int STALL_MAX_NS = 400;
  localparam int STALL_MAX_CYC = STALL_MAX_NS / CLK_PERIOD_NS;
  // retention window and number of rows in the array
  localparam int ROW_COUNT = 128;
  localparam int RETAIN_NS = 4000000;
  localparam int ROW_LIMIT_CYC = RETAIN_NS / ROW_COUNT / CLK_PERIOD_NS;
  localparam int ROW_W = 7;
  localparam int TMR_W = 11;
  localparam int REF_CNT_W = 6;
  localparam logic [ROW_W-1:0] ROW_RESET = 7'h00;
  localparam logic [TMR_W-1:0] TMR_RESET = 11'h000;
  typedef enum logic [1:0] {
    DRA_IDLE = 2'b00,
    DRA_ACCESS = 2'b01,
    DRA_REFRESH = 2'b10
  } dra_state_t;
endpackage : dra_pkg

module dra_timer
  import dra_pkg::*;
(
  input wire logic i_mclk, // system clock
  input wire logic i_srst, // sync reset, active high
  input wire logic i_ce,   // clock enable
  output logic o_due       // one-cycle pulse, refresh is due
);
  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic due;
  } dra_tmr_t;

  dra_tmr_t cur;
  dra_tmr_t next_cur;

  // interval count, due pulse at its end
  always_comb begin
    next_cur = cur;
    next_cur.due = 1'b0;
    if (cur.cnt == TMR_W'(REF_INTERVAL_CYC - 1)) begin
      next_cur.cnt = TMR_RESET;
      next_cur.due = 1'b1;
    end else begin
      next_cur.cnt = cur.cnt + 11'h001;
    end
  end

  // state register
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cur <= '0;
    end else if (i_ce) begin
      cur <= next_cur;
    end
  end

  assign o_due = cur.due;

  property p_due_gap;
    @(posedge i_mclk) disable iff (i_srst || !i_ce)
      o_due |=> !o_due [*8];
  endproperty
  a_due_gap: assert property (p_due_gap)
    else $error("refresh due pulses too close");
endmodule : dra_timer

// ==== dra_refresh_arbiter.sv ====
// refresh scheduling and memory arbitration between bus access and refresh
`timescale 1ns/1ns
// Function
// - start one row refresh every 14.5 us across all 128 rows
// - each row renewed at least once per 4 ms, access delays included
// - bus master needs no extra action; it only sees a longer access
// - on simultaneous contention the bus access wins, refresh stays pending
// - access arriving mid-refresh waits at most 400 ns
// - refresh grant only asserted while no memory access is in progress
// - refresh logic drives its own row strobe and row address
// - access starts only with address in range; only those block refresh
module dra_refresh_arbiter
  import dra_pkg::*;
(
  input wire logic i_mclk,             // system clock, 100 MHz
  input wire logic i_srst,             // sync reset, active high
  input wire logic i_ce,               // clock enable, freezes all state
  input wire logic i_access_req,       // bus cycle in progress, level
  input wire logic i_address_in_range, // latched address is on board
  output logic o_access_go,            // start/hold access timing chain
  output logic o_refresh_grant,        // refresh operation granted
  output logic o_row_strobe,           // refresh row strobe
  output logic [ROW_W-1:0] o_row_addr  // refresh row address
);
  typedef struct packed {
    dra_state_t state;
    logic pending;
    logic [REF_CNT_W-1:0] ref_cnt;
    logic [ROW_W-1:0] row;
    logic grant;
    logic strobe;
    logic go;
    logic [15:0] since_ref;
  } dra_arb_t;

  dra_arb_t cur;
  dra_arb_t next_cur;
  logic due;

  // interval timer flags a due refresh
  dra_timer u_timer (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .o_due(due)
  );

  // arbitration and refresh sequencing
  always_comb begin
    next_cur = cur;
    if (due) begin
      next_cur.pending = 1'b1;
    end
    case (cur.state)
      DRA_IDLE: begin
        if (i_access_req && i_address_in_range) begin
          next_cur.state = DRA_ACCESS;
          next_cur.go = 1'b1;
        end else if (cur.pending) begin
          next_cur.state = DRA_REFRESH;
          next_cur.grant = 1'b1;
          next_cur.strobe = 1'b1;
          next_cur.ref_cnt = '0;
          next_cur.pending = due; // new due wins over the clear
        end
      end
      DRA_ACCESS: begin
        // access runs as long as the master holds it
        if (!i_access_req) begin
          next_cur.state = DRA_IDLE;
          next_cur.go = 1'b0;
        end
      end
      DRA_REFRESH: begin
        next_cur.ref_cnt = cur.ref_cnt + 6'h01;
        if (cur.ref_cnt == REF_CNT_W'(REF_STROBE_CYC - 1)) begin
          next_cur.strobe = 1'b0;
        end
        if (cur.ref_cnt == REF_CNT_W'(REF_TOTAL_CYC - 1)) begin
          next_cur.state = DRA_IDLE;
          next_cur.grant = 1'b0;
          next_cur.row = cur.row + 7'h01;
        end
      end
      default: begin
        next_cur.state = DRA_IDLE;
        next_cur.grant = 1'b0;
        next_cur.strobe = 1'b0;
        next_cur.go = 1'b0;
      end
    endcase
    // enabled cycles since the last refresh start
    if (next_cur.grant && !cur.grant) begin
      next_cur.since_ref = 16'h0000;
    end else if (cur.since_ref != 16'hffff) begin
      next_cur.since_ref = cur.since_ref + 16'h0001;
    end
  end

  // state register
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cur <= '0;
    end else if (i_ce) begin
      cur <= next_cur;
    end
  end

  // outputs straight from the state register
  assign o_access_go = cur.go;
  assign o_refresh_grant = cur.grant;
  assign o_row_strobe = cur.strobe;
  assign o_row_addr = cur.row; // own row address

  property p_due_grant;
    @(posedge i_mclk) disable iff (i_srst || !i_ce)
      $rose(o_refresh_grant) |-> $past(cur.pending);
  endproperty
  a_due_grant: assert property (p_due_grant)
    else $error("refresh started without a due request");

  property p_retain;
    @(posedge i_mclk) disable iff (i_srst || !i_ce)
      cur.since_ref <= 16'(ROW_LIMIT_CYC);
  endproperty
  a_retain: assert property (p_retain)
    else $error("row refresh gap exceeds retention limit");

  property p_hold_access;
    @(posedge i_mclk) disable iff (i_srst || !i_ce)
      o_access_go && i_access_req |=> o_access_go;
  endproperty
  a_hold_access: assert property (p_hold_access)
    else $error("access dropped while master still holds it");

  property p_bus_wins;
    @(posedge i_mclk) disable iff (i_srst || !i_ce)
      cur.state == DRA_IDLE && i_access_req && i_address_in_range
        |=> o_access_go && !o_refresh_grant;
  endproperty
  a_bus_wins: assert property (p_bus_wins)
    else $error("bus access lost contention to refresh");

  property p_stall;
    @(posedge i_mclk) disable iff (i_srst || !i_ce)
      i_access_req && i_address_in_range && !o_access_go
        |-> ##[1:40] o_access_go;
  endproperty
  a_stall: assert property (p_stall)
    else $error("access stalled longer than 400 ns");

  property p_exclusive;
    @(posedge i_mclk) disable iff (i_srst || !i_ce)
      o_refresh_grant |-> !o_access_go;
  endproperty
  a_exclusive: assert property (p_exclusive)
    else $error("refresh granted during an access");

  property p_strobe;
    @(posedge i_mclk) disable iff (i_srst || !i_ce)
      $rose(o_refresh_grant) |-> o_row_strobe [*8];
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("refresh row strobe too short");

  property p_in_range;
    @(posedge i_mclk) disable iff (i_srst || !i_ce)
      $rose(o_access_go) |-> $past(i_address_in_range);
  endproperty
  a_in_range: assert property (p_in_range)
    else $error("access started for out-of-range address");

  property p_row_step;
    @(posedge i_mclk) disable iff (i_srst || !i_ce)
      $fell(o_refresh_grant) |-> o_row_addr == $past(o_row_addr) + 7'h01;
  endproperty
  a_row_step: assert property (p_row_step)
    else $error("row address did not advance by one");

  property p_strobe_in_grant;
    @(posedge i_mclk) disable iff (i_srst || !i_ce)
      o_row_strobe |-> o_refresh_grant;
  endproperty
  a_strobe_in_grant: assert property (p_strobe_in_grant)
    else $error("row strobe outside a refresh");

  // strobe low before the refresh ends
  property p_precharge;
    @(posedge i_mclk) disable iff (i_srst || !i_ce)
      $fell(o_refresh_grant) |-> !$past(o_row_strobe);
  endproperty
  a_precharge: assert property (p_precharge)
    else $error("row strobe still high at refresh end");

  // refresh proceeds once the array is free
  property p_proceed;
    @(posedge i_mclk) disable iff (i_srst || !i_ce)
      cur.state == DRA_IDLE && cur.pending
        && !(i_access_req && i_address_in_range) |=> o_refresh_grant;
  endproperty
  a_proceed: assert property (p_proceed)
    else $error("pending refresh not granted on a free array");

  // clock enable low holds every state bit
  property p_freeze;
    @(posedge i_mclk) disable iff (i_srst)
      !i_ce |=> $stable(cur);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while clock enable was low");

  c_refresh: cover property (@(posedge i_mclk) $fell(o_refresh_grant));
  c_contend: cover property (@(posedge i_mclk)
    cur.pending && $rose(o_access_go));
  c_stalled: cover property (@(posedge i_mclk)
    o_refresh_grant && i_access_req && i_address_in_range);
  c_wrap: cover property (@(posedge i_mclk)
    $fell(o_refresh_grant) && o_row_addr == 7'h00);
  c_freeze: cover property (@(posedge i_mclk) !i_ce && o_refresh_grant);
endmodule : dra_refresh_arbiter

// ==== dra_bus_model.sv ====
// bus master and access timing chain model facing the arbiter
`timescale 1ns/1ns
module dra_bus_model (
  input wire logic i_mclk,       // system clock
  input wire logic i_start,      // begin one bus cycle
  input wire logic i_rng,        // address lies on board
  input wire logic [7:0] i_hold, // cycles held after go
  input wire logic i_go,         // access go from arbiter
  output logic o_req,            // access request level
  output logic o_range,          // address in range
  output logic o_busy            // cycle in flight
);
  logic [7:0] cnt;
  initial begin
    o_req = 1'b0;
    o_range = 1'b0;
    o_busy = 1'b0;
    cnt = 8'h00;
  end
  always @(posedge i_mclk) begin
    if (i_start && !o_busy) begin
      o_req <= #1 1'b1;
      o_range <= #1 i_rng;
      o_busy <= 1'b1;
      cnt <= i_hold;
    end else if (o_req && (i_go || !o_range)) begin
      if (cnt == 8'h00) o_req <= #1 1'b0;
      cnt <= cnt - 8'h01;
    end else if (!o_req && !i_go) begin
      o_busy <= 1'b0;
      o_range <= #1 ~o_range; // released decode is not held
    end
  end
endmodule : dra_bus_model

// ==== tb_top.sv ====
// self-checking bench for the refresh arbiter
`timescale 1ns/1ns
module tb_top;
  import dra_pkg::*;
  logic i_mclk, i_srst, i_ce, start, rng, go, grant, strobe;
  logic req, range, busy;
  logic pg = 1'b0;
  logic [7:0] hold;
  logic [ROW_W-1:0] row;
  logic [2:0] sig;
  logic [9:0] snap;
  int errors, n_compared, cyc, lastr, gap, glen, slen, lat, alat;
  int q[$];
  assign sig = {busy, grant, go};
  dra_refresh_arbiter dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_ce(i_ce),
    .i_access_req(req), .i_address_in_range(range), .o_access_go(go),
    .o_refresh_grant(grant), .o_row_strobe(strobe), .o_row_addr(row));
  dra_bus_model bus (.i_mclk(i_mclk), .i_start(start), .i_rng(rng),
    .i_hold(hold), .i_go(go), .o_req(req), .o_range(range), .o_busy(busy));
  // clock at 100 MHz
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  // bounded wait for go, grant or busy to reach a level
  task automatic wait_for(input int k, input logic v, input int mx,
    input logic must);
    lat = 0;
    while (sig[k] !== v && lat < mx) begin
      @(posedge i_mclk) #1;
      lat++;
    end
    if (must && lat >= mx) begin
      errors++;
      complete_run;
    end
  endtask : wait_for
  // one bus cycle through the master model
  task automatic access(input logic r, input int h, input int mx);
    rng = r;
    hold = h[7:0];
    start = 1'b1;
    @(posedge i_mclk) #1;
    start = 1'b0;
    // an in-range access that never gets go is a failure
    wait_for(0, 1'b1, mx, r);
    alat = lat;
    if (!r) check(lat, mx);
    wait_for(2, 1'b0, 400, 1'b1);
  endtask : access
  // watch refreshes and take the oldest noted row
  always @(negedge i_mclk) begin
    if (i_srst === 1'b0) begin
      if ((go & grant) !== 1'b0) check(1, 0);
      // frozen cycles do not count toward lengths or gaps
      if (i_ce === 1'b1) begin
        cyc++;
        glen += grant;
        slen += strobe;
      end
      if (grant === 1'b1 && pg === 1'b0) begin
        gap = cyc - lastr;
        lastr = cyc;
        check(gap <= ROW_LIMIT_CYC, 1);
        if (q.size() > 0) check(row, q.pop_front());
      end
      if (grant === 1'b0 && pg === 1'b1) begin
        check(glen, REF_TOTAL_CYC);
        check(slen, REF_STROBE_CYC);
        glen = 0;
        slen = 0;
      end
      pg = grant;
    end
  end
  // main sequence
  initial begin
    i_srst = 1'b1;
    i_ce = 1'b1;
    start = 1'b0;
    rng = 1'b0;
    hold = 8'h00;
    void'($urandom(17438));
    repeat (10) @(posedge i_mclk);
    #1 i_srst = 1'b0;
    check({go, grant, strobe, row}, 0);
    for (int i = 0; i < 10; i++) q.push_back(i);
    access(1'b0, 5, 12);
    check(alat, 12);
    access(1'b1, $urandom_range(1, 20), 12);
    check(alat, 1);
    wait_for(1, 1'b1, 1600, 1'b1);
    access(1'b1, 3, 60);
    check(alat > 1 && alat <= STALL_MAX_CYC, 1);
    // access still open when the next refresh falls due
    repeat (1380) @(posedge i_mclk) #1;
    access(1'b1, $urandom_range(60, 120), 12);
    wait_for(1, 1'b1, 8, 1'b1);
    check(grant, 1'b1);
    repeat (3) begin
      repeat ($urandom_range(10, 900)) @(posedge i_mclk) #1;
      access(1'($urandom_range(0, 1)), $urandom_range(1, 30), 60);
    end
    // clock enable low freezes a running refresh
    wait_for(1, 1'b1, 1600, 1'b1);
    i_ce = 1'b0;
    snap = {go, grant, strobe, row};
    repeat (20) @(posedge i_mclk) #1;
    check({go, grant, strobe, row}, snap);
    i_ce = 1'b1;
    repeat (3) begin
      wait_for(1, 1'b0, 40, 1'b1);
      wait_for(1, 1'b1, 1600, 1'b1);
    end
    check(gap, REF_INTERVAL_CYC);
    wait_for(1, 1'b0, 40, 1'b1);
    complete_run;
  end
endmodule : tb_top
